//--- hdl/hmac_pkg.sv
// Package for the halfword multiply-accumulate datapath: register map,
// field positions, reset values and the issue and result carriers.
// Assumes a single core clock and an APB master with 32-bit data.
//
// Overview of operation
// - The cross form multiplies the low half of the first source by the high half of the second.
// - The high form multiplies the high halves of both sources.
// - The product is added to the target value in a 33-bit sum whose top bit is the carry or extra sign.
// - Signed variants treat both halfwords as two's complement and accumulate a signed product.
// - Unsigned variants treat both halfwords as magnitudes and accumulate an unsigned product.
// - Modulo variants write the low 32 bits of the sum and drop the top bit without saturating.
// - Saturating variants write the low 32 bits of the sum unchanged when nothing overflows.
// - Signed saturation clamps to the most negative or the most positive 32-bit value.
// - Unsigned saturation forces all ones when the sum carries out, else writes the low 32 bits.
// - With the record bit set, the negative, positive, zero and sticky-copy condition bits follow the result.
// - With overflow-enable set the sticky and range-exceeded flags are updated, otherwise left alone.
package hmac_pkg;

    // Register byte addresses.
    localparam logic [7:0] CTRL_ADDR    = 8'h00;
    localparam logic [7:0] EXC_ADDR     = 8'h04;
    localparam logic [7:0] COND_ADDR    = 8'h08;
    localparam logic [7:0] RESULT_ADDR  = 8'h0c;
    localparam logic [7:0] INT_ST_ADDR  = 8'h10;
    localparam logic [7:0] INT_MSK_ADDR = 8'h14;
    localparam logic [7:0] COUNT_ADDR   = 8'h18;

    // Field positions.
    localparam int CTRL_EN_BIT  = 0;
    localparam int EXC_RNG_BIT  = 0;
    localparam int EXC_STK_BIT  = 1;
    localparam int EV_DONE_BIT  = 0;
    localparam int EV_RNG_BIT   = 1;
    localparam int EV_SAT_BIT   = 2;
    localparam int EV_WIDTH     = 3;

    // Reset values.
    localparam logic        CTRL_EN_RST = 1'b1;
    localparam logic [2:0]  INT_MSK_RST = 3'h0;
    localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

    // Operand and sum widths.
    localparam int HALF_W = 16;
    localparam int WORD_W = 32;
    localparam int SUM_W  = 33;

    // Which halfwords feed the multiplier.
    typedef enum logic {FORM_CROSS, FORM_HIGH} mac_form_e;

    // One issued operation as decoded by the core.
    typedef struct packed {
        mac_form_e form;
        logic      is_signed;
        logic      saturate;
        logic      record_bit;
        logic      overflow_enable;
    } mac_op_s;

    // Condition field, most significant bit first.
    typedef struct packed {
        logic negative_flag;
        logic positive_flag;
        logic zero_flag;
        logic sticky_copy;
    } cond_field_s;

    // Datapath answer for one operation.
    typedef struct packed {
        logic [31:0] value;
        logic        overflow;
        logic        saturated;
    } mac_res_s;

endpackage

//--- hdl/hmac_mul.sv
// Halfword selector and 16x16 multiplier of the accumulate datapath.
// Purely combinational; the caller registers the final result.
`timescale 1ns/1ps
`default_nettype none
module hmac_mul (
    // Operands.
    input  wire logic                 form_high_i,
    input  wire logic                 is_signed_i,
    input  wire logic [31:0]          first_source_reg_i,
    input  wire logic [31:0]          second_source_reg_i,
    // Product.
    output logic [31:0]               product_o
);
    logic [15:0] op_a;
    logic [15:0] op_b;

    // Halfword pick; bit 0 in the big-endian view is our bit 31.
    always_comb begin
        if (form_high_i) begin
            op_a = first_source_reg_i[31:16];
            op_b = second_source_reg_i[31:16];
        end else begin
            op_a = first_source_reg_i[15:0];
            op_b = second_source_reg_i[31:16];
        end
    end

    // Extending by one bit lets one signed multiplier serve both kinds.
    always_comb begin
        logic signed [16:0] ea;
        logic signed [16:0] eb;
        logic signed [33:0] p;
        ea = {is_signed_i & op_a[15], op_a};
        eb = {is_signed_i & op_b[15], op_b};
        p  = ea * eb;
        product_o = p[31:0];
    end
endmodule // hmac_mul
`default_nettype wire

//--- hdl/hmac_sat.sv
// Accumulator and saturation stage: 33-bit sum, clamping and overflow.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module hmac_sat (
    // Controls.
    input  wire logic                 is_signed_i,
    input  wire logic                 saturate_i,
    // Data.
    input  wire logic [31:0]          product_i,
    input  wire logic [31:0]          target_i,
    // Result.
    output hmac_pkg::mac_res_s        res_o
);
    logic [32:0] sum;
    logic        s_ovf;

    // Sign or zero extension picks the meaning of the top sum bit.
    always_comb begin
        logic [32:0] ep;
        logic [32:0] et;
        ep  = {is_signed_i & product_i[31], product_i};
        et  = {is_signed_i & target_i[31], target_i};
        sum = ep + et;
    end

    // Same-sign addends with a flipped result sign mean signed overflow.
    assign s_ovf = (product_i[31] == target_i[31]) &&
                   (target_i[31] != sum[31]);

    always_comb begin
        res_o.value     = sum[31:0];
        res_o.saturated = 1'b0;
        res_o.overflow  = is_signed_i ? s_ovf : sum[32];
        if (saturate_i && is_signed_i && s_ovf) begin
            // Clamp toward the side the target already sits on.
            res_o.value     = {target_i[31], {31{~target_i[31]}}};
            res_o.saturated = 1'b1;
        end else if (saturate_i && !is_signed_i && sum[32]) begin
            res_o.value     = {32{1'b1}};
            res_o.saturated = 1'b1;
        end
    end
endmodule // hmac_sat
`default_nettype wire

//--- hdl/hmac_top.sv
// Halfword multiply-accumulate unit with an APB register slave.
// Assumes the decoder presents one operation per issue pulse with its
// operands already read from the register file; the result returns one
// cycle later. APB answers with one access cycle, no wait states.
`timescale 1ns/1ps
`default_nettype none
module hmac_top (
    // Clock and reset.
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_n_i,
    // Issue from the instruction decoder.
    input  wire logic                 issue_valid_i,
    input  wire hmac_pkg::mac_op_s    issue_op_i,
    input  wire logic [31:0]          first_source_reg_i,
    input  wire logic [31:0]          second_source_reg_i,
    input  wire logic [31:0]          accumulate_target_reg_i,
    // Write-back to the register file and condition register.
    output logic                      wb_valid_o,
    output logic [31:0]               wb_data_o,
    output logic                      cond_valid_o,
    output hmac_pkg::cond_field_s     first_condition_field_o,
    output logic [1:0]                integer_exception_register_o,
    // APB slave.
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [7:0]           paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic [31:0]               prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    // Interrupt.
    output logic                      irq_o
);

    // Register state.
    logic                             enable_r;
    logic                             range_exceeded_flag_r;
    logic                             sticky_flag_r;
    hmac_pkg::cond_field_s            cond_r;
    logic [31:0]                      result_r;
    logic [hmac_pkg::EV_WIDTH-1:0]    int_status_r;
    logic [hmac_pkg::EV_WIDTH-1:0]    int_mask_r;
    logic [31:0]                      op_count_r;

    // Datapath wires.
    logic                             accept;
    logic [31:0]                      product;
    hmac_pkg::mac_res_s               res;
    logic                             rng_nxt;
    logic                             so_nxt;
    hmac_pkg::cond_field_s            cond_nxt;
    logic [hmac_pkg::EV_WIDTH-1:0]    events;

    // APB decode.
    logic                             apb_setup;
    logic                             apb_write;
    logic                             addr_ok;
    logic [31:0]                      rdata_nxt;

    // An operation is only taken while software has the unit enabled.
    assign accept = issue_valid_i && enable_r;

    hmac_mul u_mul (
        .form_high_i         (issue_op_i.form == hmac_pkg::FORM_HIGH),
        .is_signed_i         (issue_op_i.is_signed),
        .first_source_reg_i  (first_source_reg_i),
        .second_source_reg_i (second_source_reg_i),
        .product_o           (product)
    );

    hmac_sat u_sat (
        .is_signed_i (issue_op_i.is_signed),
        .saturate_i  (issue_op_i.saturate),
        .product_i   (product),
        .target_i    (accumulate_target_reg_i),
        .res_o       (res)
    );

    // Exception flags only move when the operation asks for it.
    always_comb begin
        rng_nxt = range_exceeded_flag_r;
        so_nxt = sticky_flag_r;
        if (issue_op_i.overflow_enable) begin
            rng_nxt = res.overflow;
            so_nxt = sticky_flag_r | res.overflow;
        end
    end

    // Condition bits compare the written value as a signed word.
    always_comb begin
        cond_nxt.negative_flag = res.value[31];
        cond_nxt.positive_flag = !res.value[31] &&
                                 (res.value != hmac_pkg::ZERO_WORD);
        cond_nxt.zero_flag     = (res.value == hmac_pkg::ZERO_WORD);
        cond_nxt.sticky_copy   = so_nxt;
    end

    // Events raised by a completed operation.
    always_comb begin
        events = '0;
        events[hmac_pkg::EV_DONE_BIT] = accept;
        events[hmac_pkg::EV_RNG_BIT]  = accept && res.overflow;
        events[hmac_pkg::EV_SAT_BIT]  = accept && res.saturated;
    end

    // APB phases: setup is answered by the registered ready one cycle on.
    assign apb_setup = psel_i && !penable_i;
    assign apb_write = psel_i && penable_i && pready_o && pwrite_i;

    always_comb begin
        addr_ok = 1'b1;
        rdata_nxt = hmac_pkg::ZERO_WORD;
        unique case (paddr_i)
            hmac_pkg::CTRL_ADDR:
                rdata_nxt[hmac_pkg::CTRL_EN_BIT] = enable_r;
            hmac_pkg::EXC_ADDR: begin
                rdata_nxt[hmac_pkg::EXC_RNG_BIT] = range_exceeded_flag_r;
                rdata_nxt[hmac_pkg::EXC_STK_BIT] = sticky_flag_r;
            end
            hmac_pkg::COND_ADDR:
                rdata_nxt[3:0] = cond_r;
            hmac_pkg::RESULT_ADDR:
                rdata_nxt = result_r;
            hmac_pkg::INT_ST_ADDR:
                rdata_nxt[hmac_pkg::EV_WIDTH-1:0] = int_status_r;
            hmac_pkg::INT_MSK_ADDR:
                rdata_nxt[hmac_pkg::EV_WIDTH-1:0] = int_mask_r;
            hmac_pkg::COUNT_ADDR:
                rdata_nxt = op_count_r;
            default:
                addr_ok = 1'b0;
        endcase
    end

    // Ready, error and read data are all captured in the setup cycle.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= hmac_pkg::ZERO_WORD;
        end else begin
            pready_o  <= apb_setup;
            pslverr_o <= apb_setup && !addr_ok;
            prdata_o  <= (apb_setup && !pwrite_i) ? rdata_nxt
                                                  : hmac_pkg::ZERO_WORD;
        end
    end

    // Control and interrupt mask.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            enable_r   <= hmac_pkg::CTRL_EN_RST;
            int_mask_r <= hmac_pkg::INT_MSK_RST;
        end else if (apb_write) begin
            if (paddr_i == hmac_pkg::CTRL_ADDR) begin
                enable_r <= pwdata_i[hmac_pkg::CTRL_EN_BIT];
            end
            if (paddr_i == hmac_pkg::INT_MSK_ADDR) begin
                int_mask_r <= pwdata_i[hmac_pkg::EV_WIDTH-1:0];
            end
        end
    end

    // Exception flags; a software write loses to a same-cycle update so
    // that an overflow is never dropped while the flags are being reset.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            range_exceeded_flag_r <= 1'b0;
            sticky_flag_r         <= 1'b0;
        end else if (accept) begin
            range_exceeded_flag_r <= rng_nxt;
            sticky_flag_r         <= so_nxt;
        end else if (apb_write && paddr_i == hmac_pkg::EXC_ADDR) begin
            range_exceeded_flag_r <= pwdata_i[hmac_pkg::EXC_RNG_BIT];
            sticky_flag_r         <= pwdata_i[hmac_pkg::EXC_STK_BIT];
        end
    end

    // Condition field holds the last recorded outcome.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cond_r <= '0;
        end else if (accept && issue_op_i.record_bit) begin
            cond_r <= cond_nxt;
        end
    end

    // Last written value and operation count for software inspection.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            result_r   <= hmac_pkg::ZERO_WORD;
            op_count_r <= hmac_pkg::ZERO_WORD;
        end else if (accept) begin
            result_r   <= res.value;
            op_count_r <= op_count_r + 32'h0000_0001;
        end
    end

    // Sticky event bits: write one to clear, a new event wins the tie.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            int_status_r <= '0;
        end else begin
            if (apb_write && paddr_i == hmac_pkg::INT_ST_ADDR) begin
                int_status_r <= (int_status_r &
                                 ~pwdata_i[hmac_pkg::EV_WIDTH-1:0]) | events;
            end else begin
                int_status_r <= int_status_r | events;
            end
        end
    end

    // Level interrupt, registered so the pin never glitches.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(int_status_r & int_mask_r);
        end
    end

    // Write-back outputs, one cycle after issue.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wb_valid_o                   <= 1'b0;
            wb_data_o                    <= hmac_pkg::ZERO_WORD;
            cond_valid_o                 <= 1'b0;
            first_condition_field_o      <= '0;
            integer_exception_register_o <= 2'h0;
        end else begin
            wb_valid_o   <= accept;
            cond_valid_o <= accept && issue_op_i.record_bit;
            if (accept) begin
                wb_data_o               <= res.value;
                first_condition_field_o <= cond_nxt;
                integer_exception_register_o <= {so_nxt, rng_nxt};
            end
        end
    end

endmodule // hmac_top
`default_nettype wire

//--- dv/hmac_assertions.sv
// Checker for the multiply-accumulate unit, watching hmac_top ports only.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module hmac_assertions (
    // Clock and reset.
    input wire logic                  ref_clk_i,
    input wire logic                  rst_n_i,
    // Issue side.
    input wire logic                  issue_valid_i,
    input wire hmac_pkg::mac_op_s     issue_op_i,
    input wire logic [31:0]           first_source_reg_i,
    input wire logic [31:0]           second_source_reg_i,
    input wire logic [31:0]           accumulate_target_reg_i,
    // Write-back side.
    input wire logic                  wb_valid_o,
    input wire logic [31:0]           wb_data_o,
    input wire logic                  cond_valid_o,
    input wire hmac_pkg::cond_field_s first_condition_field_o,
    input wire logic [1:0]            integer_exception_register_o,
    // APB handshake.
    input wire logic                  psel_i,
    input wire logic                  penable_i,
    input wire logic                  pready_o
);
    hmac_pkg::mac_op_s op_r;
    logic [15:0]       half_a;
    logic [31:0]       prod_nxt;
    logic [31:0]       prod_r;
    logic [31:0]       tgt_r;
    logic [32:0]       sum_w;
    logic              ovf_w;
    // Own product, so a slip shared with the design cannot hide.
    always_comb begin
        half_a = (issue_op_i.form == hmac_pkg::FORM_HIGH) ?
                 first_source_reg_i[31:16] : first_source_reg_i[15:0];
        if (issue_op_i.is_signed)
            prod_nxt = $signed(half_a) * $signed(second_source_reg_i[31:16]);
        else
            prod_nxt = half_a * second_source_reg_i[31:16];
    end
    // Shadow of the operation that the next write-back answers.
    always_ff @(posedge ref_clk_i) begin
        op_r   <= issue_op_i;
        prod_r <= prod_nxt;
        tgt_r  <= accumulate_target_reg_i;
    end
    // Signed sign test or unsigned carry, by operand kind.
    assign sum_w = {1'b0, prod_r} + {1'b0, tgt_r};
    assign ovf_w = op_r.is_signed ?
        ((prod_r[31] == tgt_r[31]) && (tgt_r[31] != sum_w[31])) : sum_w[32];
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence apb_setup_s;
        psel_i && !penable_i;
    endsequence
    sequence apb_access_s;
        psel_i && penable_i && pready_o;
    endsequence
    AST_APB_ANSWER: assert property (apb_setup_s |=> apb_access_s)
        else $error("APB access did not complete in one cycle.");
    AST_WB_CAUSE: assert property (wb_valid_o |-> $past(issue_valid_i))
        else $error("Write-back without an issue one cycle before.");
    AST_MODULO: assert property (wb_valid_o && !op_r.saturate |->
        wb_data_o == sum_w[31:0])
        else $error("Wrapped result differs from the low sum bits.");
    AST_SAT_PASS: assert property (wb_valid_o && op_r.saturate && !ovf_w |->
        wb_data_o == sum_w[31:0])
        else $error("Saturating result altered without overflow.");
    AST_SAT_SIGNED: assert property (wb_valid_o && op_r.saturate &&
        op_r.is_signed && ovf_w |-> wb_data_o == {tgt_r[31], {31{~tgt_r[31]}}})
        else $error("Signed clamp value wrong.");
    AST_SAT_UNSIGNED: assert property (wb_valid_o && op_r.saturate &&
        !op_r.is_signed && sum_w[32] |-> wb_data_o == 32'hffff_ffff)
        else $error("Unsigned clamp value wrong.");
    AST_COND_VALID: assert property (wb_valid_o |-> cond_valid_o == op_r.record_bit)
        else $error("Condition update does not follow the record bit.");
    AST_COND_FLAGS: assert property (cond_valid_o |-> first_condition_field_o ==
        {wb_data_o[31], !wb_data_o[31] && (wb_data_o != 32'h0),
         wb_data_o == 32'h0, integer_exception_register_o[1]})
        else $error("Condition field does not match the result.");
    AST_OV_FLAG: assert property (wb_valid_o && op_r.overflow_enable |->
        integer_exception_register_o[0] == ovf_w)
        else $error("Range-exceeded flag wrong.");
    AST_STICKY: assert property (wb_valid_o && op_r.overflow_enable && ovf_w |->
        integer_exception_register_o == 2'h3)
        else $error("Sticky flag not set with overflow.");
    AST_EXC_HOLD: assert property (wb_valid_o && !op_r.overflow_enable |->
        $stable(integer_exception_register_o))
        else $error("Exception flags moved with overflow-enable clear.");
endmodule // hmac_assertions
bind hmac_top hmac_assertions i_hmac_assertions (
    .ref_clk_i, .rst_n_i, .issue_valid_i, .issue_op_i, .first_source_reg_i,
    .second_source_reg_i, .accumulate_target_reg_i, .wb_valid_o, .wb_data_o,
    .cond_valid_o, .first_condition_field_o, .integer_exception_register_o,
    .psel_i, .penable_i, .pready_o
);
`default_nettype wire

//--- dv/hmac_core_model.sv
// Model of the core decoder and register file feeding hmac_top.
// Assumes the bench calls one task at a time from a single thread.
`timescale 1ns/1ps
`default_nettype none
module hmac_core_model (
    // Clock.
    input  wire logic         clk_i,
    // Issue towards the unit.
    output logic              issue_valid_o,
    output hmac_pkg::mac_op_s issue_op_o,
    output logic [31:0]       src_a_o,
    output logic [31:0]       src_b_o,
    output logic [31:0]       tgt_o
);
    // Quiet issue port at time zero.
    initial begin
        issue_valid_o = 1'b0;
        {issue_op_o, src_a_o, src_b_o, tgt_o} = '0;
    end
    // One operation right after an edge; calls in a row go back to back.
    task automatic send(input hmac_pkg::mac_op_s op,
                        input logic [31:0] a, b, t);
        @(posedge clk_i);
        issue_valid_o <= 1'b1;
        issue_op_o    <= op;
        src_a_o       <= a;
        src_b_o       <= b;
        tgt_o         <= t;
    endtask
    // Stale operands are inverted so the unit cannot lean on them.
    task automatic idle();
        @(posedge clk_i);
        issue_valid_o <= 1'b0;
        src_a_o       <= ~src_a_o;
        src_b_o       <= ~src_b_o;
        tgt_o         <= ~tgt_o;
    endtask
endmodule // hmac_core_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for hmac_top: core model issues, APB tasks reach regs.
// Assumes the hand-over timing: answer one cycle after issue.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("Error at %0t ns: got %h, expected %h", $time, got, exp); \
    end \
end
module tb_top;
    logic                  clk;
    logic                  rst_n;
    logic                  issue_valid;
    hmac_pkg::mac_op_s     issue_op;
    logic [31:0]           src_a;
    logic [31:0]           src_b;
    logic [31:0]           tgt;
    logic                  wb_valid;
    logic [31:0]           wb_data;
    logic                  cond_valid;
    hmac_pkg::cond_field_s cond;
    logic [1:0]            exc;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [7:0]            paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  irq;
    logic [31:0]           rd;
    logic                  err;
    int                    n_fail;
    int                    cmp_count;
    int                    cycles;
    int                    n_ops;
    hmac_core_model i_hmac_core_model (.clk_i(clk), .issue_valid_o(issue_valid),
        .issue_op_o(issue_op), .src_a_o(src_a), .src_b_o(src_b), .tgt_o(tgt));
    hmac_top i_hmac_top (.ref_clk_i(clk), .rst_n_i(rst_n),
        .issue_valid_i(issue_valid), .issue_op_i(issue_op),
        .first_source_reg_i(src_a), .second_source_reg_i(src_b),
        .accumulate_target_reg_i(tgt), .wb_valid_o(wb_valid),
        .wb_data_o(wb_data), .cond_valid_o(cond_valid),
        .first_condition_field_o(cond), .integer_exception_register_o(exc),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq));
    // 40 MHz core clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Prints the counts and the verdict, then stops.
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One APB transfer; waits for pready without assuming its delay.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // Only the bench timeout may end this wait.
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Issues one operation and checks the write-back one cycle later.
    task automatic op_chk(input logic [4:0] o, input logic [31:0] a, b, t,
                          input logic [31:0] e, input logic [1:0] ex,
                          input logic [3:0] ec);
        i_hmac_core_model.send(hmac_pkg::mac_op_s'(o), a, b, t);
        i_hmac_core_model.idle();
        n_ops++;
        #1;
        `CHK(wb_valid, 1'b1)
        `CHK(wb_data, e)
        `CHK(exc, ex)
        `CHK(cond_valid, o[1])
        if (o[1]) `CHK(cond, ec)
    endtask
    // A hang is cut short well beyond the expected run length.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            give_verdict();
        end
    end
    // Main sequence; op codes are {form, signed, saturate, record, oe}.
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {n_fail, cmp_count, cycles, n_ops} = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, hmac_pkg::CTRL_ADDR, 32'h0);
        `CHK(rd, 32'h1)
        apb(1'b0, hmac_pkg::INT_MSK_ADDR, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'h40, 32'h0);
        `CHK({err, rd}, 33'h1_0000_0000)
        op_chk(5'b00000, 32'h1234_0003, 32'h0005_9999, 32'h10,
               32'h1f, 2'h0, 4'h0);
        op_chk(5'b10000, 32'h0002_ffff, 32'h0007_0001, 32'hffff_fff5,
               32'h3, 2'h0, 4'h0);
        op_chk(5'b10111, 32'h0002_ffff, 32'h0007_0001, 32'hffff_fff5,
               32'hffff_ffff, 2'h3, 4'h9);
        op_chk(5'b01000, 32'h0000_fffe, 32'h0003_0000, 32'h10,
               32'ha, 2'h3, 4'h0);
        i_hmac_core_model.send(hmac_pkg::mac_op_s'(5'b11100), 32'hffff_0000,
                               32'h0004_0000, 32'h2);
        n_ops++;
        op_chk(5'b11101, 32'h7fff_0000, 32'h7fff_0000, 32'h7000_0000,
               32'h7fff_ffff, 2'h3, 4'h0);
        op_chk(5'b01101, 32'h0000_8000, 32'h7fff_0000, 32'h8000_0000,
               32'h8000_0000, 2'h3, 4'h0);
        op_chk(5'b00111, 32'h1234_0000, 32'hffff_0000, 32'h0,
               32'h0, 2'h2, 4'h3);
        apb(1'b1, hmac_pkg::EXC_ADDR, 32'h0);
        apb(1'b0, hmac_pkg::EXC_ADDR, 32'h0);
        `CHK(rd, 32'h0)
        op_chk(5'b10011, 32'h0003_0000, 32'h0003_0000, 32'h7fff_fff0,
               32'h7fff_fff9, 2'h0, 4'h4);
        op_chk(5'b01001, 32'h0000_7fff, 32'h7fff_0000, 32'h7000_0000,
               32'hafff_0001, 2'h3, 4'h0);
        apb(1'b0, hmac_pkg::COND_ADDR, 32'h0);
        `CHK(rd, 32'h4)
        apb(1'b0, hmac_pkg::RESULT_ADDR, 32'h0);
        `CHK(rd, 32'hafff_0001)
        apb(1'b0, hmac_pkg::INT_ST_ADDR, 32'h0);
        `CHK(rd, 32'h7)
        `CHK(irq, 1'b0)
        apb(1'b1, hmac_pkg::INT_MSK_ADDR, 32'h2);
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq, 1'b1)
        apb(1'b1, hmac_pkg::INT_ST_ADDR, 32'h7);
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq, 1'b0)
        apb(1'b1, hmac_pkg::CTRL_ADDR, 32'h0);
        i_hmac_core_model.send(hmac_pkg::mac_op_s'(5'b00000), 32'h1, 32'h1,
                               32'h1);
        i_hmac_core_model.idle();
        #1;
        `CHK(wb_valid, 1'b0)
        apb(1'b1, hmac_pkg::CTRL_ADDR, 32'h1);
        apb(1'b0, hmac_pkg::COUNT_ADDR, 32'h0);
        `CHK(rd, 32'(n_ops))
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
